// *** dv/cfg_loader_tb.sv ***
// self-checking bench for the configuration word loader
`timescale 1ns/100ps
module cfg_loader_tb
  import cfg_loader_pkg::*;
();

  // one compare, counted, mismatch reported at once
  `define CHK(name, exp, got) \
    begin checked++; if ((got) !== (exp)) begin n_fail++; \
      $display("ERROR %s expected %h seen %h", name, exp, got); end end

  logic          hclk;
  logic          hresetn;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [2:0]    hsize;
  logic [31:0]   hwdata;
  logic          hreadyout;
  logic          hreadyout_nu;
  logic          hresp;
  logic [31:0]   hrdata;
  logic [31:0]   nv_pll_word;
  logic [31:0]   nv_pin_word;
  logic          nv_jtag_default;
  logic          sys_unlocked;
  pll_settings_t pll_s;
  pll_settings_t pll_nu;
  pin_settings_t pin_s;
  cfg_ctrl_t     ctrl_s;
  logic          remap_writes_blocked;
  logic          moddis_writes_blocked;
  logic [15:0]   user_value;
  logic          config_valid_r;
  int            n_fail;
  int            checked;
  int            cycles;
  logic [8:0]    odiv_tab [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h100};
  logic [4:0]    mult_tab [8] = '{5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h18};
  logic [3:0]    idiv_tab [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc};

  // single slave, so its ready out is the bus ready
  cfg_loader #(.USB_PRESENT(1'b1)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nv_pll_word(nv_pll_word),
    .nv_pin_word(nv_pin_word), .nv_jtag_default(nv_jtag_default),
    .sys_unlocked(sys_unlocked), .pll_settings_r(pll_s), .pin_settings_r(pin_s),
    .cfg_ctrl_r(ctrl_s), .remap_writes_blocked(remap_writes_blocked),
    .moddis_writes_blocked(moddis_writes_blocked), .user_value(user_value),
    .config_valid_r(config_valid_r));

  // variant without usb, never selected; only its decoded pll settings are watched
  cfg_loader #(.USB_PRESENT(1'b0)) i_dut_nousb (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b0), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout_nu),
    .hreadyout(hreadyout_nu), .hresp(), .hrdata(), .nv_pll_word(nv_pll_word),
    .nv_pin_word(nv_pin_word), .nv_jtag_default(nv_jtag_default),
    .sys_unlocked(sys_unlocked), .pll_settings_r(pll_nu), .pin_settings_r(),
    .cfg_ctrl_r(), .remap_writes_blocked(), .moddis_writes_blocked(), .user_value(),
    .config_valid_r());

  // 50 mhz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // reset, then watch the load sequence edge by edge
  task automatic do_reset();
    hresetn <= 1'b0;
    htrans  <= 2'h0;
    repeat (16) @(posedge hclk);
    #1;
    `CHK("rst ready", 1'b0, hreadyout)
    `CHK("rst ctrl", 4'b0001, ctrl_s)
    `CHK("rst valid", 1'b0, config_valid_r)
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    #1;
    `CHK("load ready", 1'b1, hreadyout)
    `CHK("load early", 1'b0, config_valid_r)
    @(posedge hclk);
    #1;
    `CHK("load valid", 1'b1, config_valid_r)
  endtask

  // address phase held until ready, then data phase held until ready
  task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic ahb_read(input logic [7:0] a, output logic [31:0] d);
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  // every field code, one reset each; reserved bits written as ones
  task automatic test_pll();
    logic [2:0]  k;
    logic [31:0] w;
    logic [31:0] p;
    logic [31:0] rd;
    logic [5:0]  nu;
    for (int c = 0; c < 8; c++) begin
      k = 3'(c);
      w = 32'hfff8_7888 | {13'h0, k, k[0], 4'h0, k, 1'b0, k, 1'b0, k};
      p = {k[0], k[1], k[2], ~k[0], 12'hfff, k, 13'h0a5c};
      nv_pll_word     <= w;
      nv_pin_word     <= p;
      nv_jtag_default <= k[1];
      do_reset();
      `CHK("out_div", odiv_tab[k], pll_s.out_div)
      `CHK("usb bypass", k[0], pll_s.usb_pll_bypass)
      `CHK("usb enable", ~k[0], pll_s.usb_pll_enable)
      `CHK("usb in_div", idiv_tab[k], pll_s.usb_pll_in_divider)
      `CHK("mult", mult_tab[k], pll_s.mult)
      `CHK("in_div", idiv_tab[k], pll_s.in_div)
      `CHK("vbus owner", k[0], pin_s.vbus_pin_owner)
      `CHK("id owner", k[1], pin_s.id_pin_owner)
      `CHK("remap 1shot", k[2], pin_s.remap_one_shot)
      `CHK("moddis 1shot", ~k[0], pin_s.moddis_one_shot)
      `CHK("user port", {k, 13'h0a5c}, user_value)
      `CHK("user field", {k, 13'h0a5c}, pin_s.user_value)
      nu = {pll_nu.usb_pll_enable, pll_nu.usb_pll_bypass, pll_nu.usb_pll_in_divider};
      `CHK("nousb usb", 6'h00, nu)
      `CHK("nousb mult", mult_tab[k], pll_nu.mult)
      `CHK("jtag load", k[1], ctrl_s.jtag_port_enable)
      ahb_read(OFS_PLL_WORD, rd);
      `CHK("pll word", w, rd)
      ahb_read(OFS_PIN_WORD, rd);
      `CHK("pin word", p & 32'hf000_ffff, rd)
      ahb_read(OFS_CFG_CTRL, rd);
      `CHK("ctrl word", {28'h0, k[1], 3'b001}, rd)
    end
    $display("test pll done");
  endtask

  // writes to read-only and unmapped places, and late word changes, have no effect
  task automatic test_ro();
    logic [31:0] w;
    logic [31:0] p;
    logic [8:0]  od;
    logic [31:0] rd;
    w  = nv_pll_word;
    p  = nv_pin_word;
    od = pll_s.out_div;
    ahb_write(OFS_PLL_WORD, 32'h0);
    ahb_write(OFS_PIN_WORD, 32'h0);
    ahb_write(8'h40, 32'hffff_ffff);
    // flip every field; the pll word's reserved bits stay, the pin word is flipped whole
    nv_pll_word <= w ^ 32'h0007_8777;
    nv_pin_word <= ~p;
    ahb_read(OFS_PLL_WORD, rd);
    `CHK("ro pll", w, rd)
    ahb_read(OFS_PIN_WORD, rd);
    `CHK("ro pin", p & 32'hf000_ffff, rd)
    ahb_read(8'h40, rd);
    `CHK("unmapped", 32'h0, rd)
    `CHK("okay resp", 1'b0, hresp)
    `CHK("held out_div", od, pll_s.out_div)
    $display("test read-only done");
  endtask

  // lock bits need the unlock level; a one-shot lock survives a clear
  task automatic test_lock(input logic [31:0] pin);
    logic [31:0] keep;
    logic [31:0] rd;
    keep = {18'h0, pin[29], pin[28], 12'h0};
    nv_pin_word <= pin;
    do_reset();
    sys_unlocked <= 1'b0;
    ahb_write(OFS_CFG_CTRL, 32'h0000_3008);
    ahb_read(OFS_CFG_CTRL, rd);
    `CHK("locked out", 32'h0000_0008, rd)
    `CHK("tdo off", 1'b0, ctrl_s.two_wire_tdo_use)
    `CHK("remap free", 1'b0, remap_writes_blocked)
    sys_unlocked <= 1'b1;
    ahb_write(OFS_CFG_CTRL, 32'h0000_3009);
    ahb_read(OFS_CFG_CTRL, rd);
    `CHK("locks set", 32'h0000_3009, rd)
    `CHK("remap blocked", 1'b1, remap_writes_blocked)
    `CHK("moddis blocked", 1'b1, moddis_writes_blocked)
    `CHK("jtag on", 1'b1, ctrl_s.jtag_port_enable)
    ahb_write(OFS_CFG_CTRL, 32'h0);
    ahb_read(OFS_CFG_CTRL, rd);
    `CHK("clear try", keep, rd)
    `CHK("remap kept", pin[29], remap_writes_blocked)
    `CHK("moddis kept", pin[28], moddis_writes_blocked)
    ahb_write(OFS_CFG_CTRL, 32'h0000_3000);
    ahb_read(OFS_CFG_CTRL, rd);
    `CHK("relock", 32'h0000_3000, rd)
    sys_unlocked <= 1'b0;
    $display("test lock done");
  endtask

  // inputs settled at time zero, then the scenarios in turn
  initial begin
    n_fail          = 0;
    checked         = 0;
    cycles          = 0;
    hresetn         = 1'b0;
    hsel            = 1'b1;
    haddr           = 32'h0;
    htrans          = 2'h0;
    hwrite          = 1'b0;
    hsize           = 3'h2;
    hwdata          = 32'h0;
    nv_pll_word     = 32'hffff_ffff;
    nv_pin_word     = 32'h0;
    nv_jtag_default = 1'b0;
    sys_unlocked    = 1'b0;
    @(posedge hclk);
    test_pll();
    test_ro();
    test_lock(32'h2000_5a5a);
    test_lock(32'h1000_a5a5);
    end_sim();
  end

endmodule

// *** hw/ahb_reg_port.sv ***
// ahb-lite single-word slave front end with registered read data
`timescale 1ns/100ps
module ahb_reg_port
  import cfg_loader_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic        loaded,
  input  wire logic [31:0] rd_data,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic      [7:0]  rd_addr,
  output logic             wr_en_r,
  output logic      [7:0]  wr_addr_r
);

  logic take;
  logic rd_take;

  // a read right behind a write waits one cycle so it sees the new value
  assign take      = hsel && hready && htrans[1];
  assign hreadyout = loaded && !(wr_en_r && hsel && htrans[1] && !hwrite);
  assign hresp     = 1'b0;
  assign rd_take   = take && !hwrite && hreadyout;
  assign rd_addr   = haddr[7:0];

  // address phase captured for the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_en_r   <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_en_r   <= take && hwrite && hreadyout;
      wr_addr_r <= haddr[7:0];
    end
  end

  // read data is sampled at the address phase, held through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= rd_data;
    end
  end

endmodule

// *** hw/cfg_loader.sv ***
// configuration word loader: pll setup, pin ownership and run-time control
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module cfg_loader
  import cfg_loader_pkg::*;
#(
  parameter bit USB_PRESENT = 1'b1
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic      [31:0]   hrdata,
  input  wire logic [31:0]   nv_pll_word,
  input  wire logic [31:0]   nv_pin_word,
  input  wire logic          nv_jtag_default,
  input  wire logic          sys_unlocked,
  output pll_settings_t      pll_settings_r,
  output pin_settings_t      pin_settings_r,
  output cfg_ctrl_t          cfg_ctrl_r,
  output logic               remap_writes_blocked,
  output logic               moddis_writes_blocked,
  output logic      [15:0]   user_value,
  output logic               config_valid_r
);

  logic [31:0] pll_word;
  logic [31:0] pin_word;
  logic        jtag_default;
  logic        pll_loaded;
  logic        pin_loaded;
  logic        jtag_loaded;
  logic        loaded;
  logic [7:0]  rd_addr;
  logic        wr_en_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] rd_data;
  logic        cfg_wr;
  logic        lock_wr;
  logic        ctrl_init_r;
  logic        remap_lock_r;
  logic        moddis_lock_r;
  logic        jtag_en_r;
  logic        tdo_use_r;

  cfg_word_latch #(
    .W (32)
  ) u_pll_latch (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .word_in  (nv_pll_word),
    .word_r   (pll_word),
    .loaded_r (pll_loaded)
  );

  cfg_word_latch #(
    .W (32)
  ) u_pin_latch (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .word_in  (nv_pin_word),
    .word_r   (pin_word),
    .loaded_r (pin_loaded)
  );

  // jtag enable default comes from another nonvolatile word
  cfg_word_latch #(
    .W (1)
  ) u_jtag_latch (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .word_in  (nv_jtag_default),
    .word_r   (jtag_default),
    .loaded_r (jtag_loaded)
  );

  assign loaded = pll_loaded && pin_loaded && jtag_loaded;

  // bus slave; hsize is not decoded, every transfer acts on the whole word
  ahb_reg_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .loaded    (loaded),
    .rd_data   (rd_data),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .wr_en_r   (wr_en_r),
    .wr_addr_r (wr_addr_r)
  );

  // decoded settings, refreshed only while the words are frozen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_settings_r <= '0;
      config_valid_r <= 1'b0;
    end else if (loaded) begin
      config_valid_r <= 1'b1;
      pll_settings_r.out_div <= out_div_decode(pll_word[PLL_ODIV_LSB+:3]);
      pll_settings_r.mult <= mult_decode(pll_word[PLL_MULT_LSB+:3]);
      pll_settings_r.in_div <= in_div_decode(pll_word[PLL_IDIV_LSB+:3]);
      // usb pll enable, absent parts keep it off
      pll_settings_r.usb_pll_bypass <= USB_PRESENT && pll_word[USB_BYPASS_BIT];
      pll_settings_r.usb_pll_enable <= USB_PRESENT && !pll_word[USB_BYPASS_BIT];
      pll_settings_r.usb_pll_in_divider <= USB_PRESENT ?
          in_div_decode(pll_word[USB_IDIV_LSB+:3]) : 4'h0;
    end
  end

  // pin ownership and one-shot selections
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_settings_r <= '0;
    end else if (loaded) begin
      pin_settings_r.vbus_pin_owner  <= pin_word[VBUS_OWNER_BIT];
      pin_settings_r.id_pin_owner    <= pin_word[ID_OWNER_BIT];
      pin_settings_r.remap_one_shot  <= pin_word[REMAP_1SHOT_BIT];
      pin_settings_r.moddis_one_shot <= pin_word[MODDIS_1SHOT_BIT];
      pin_settings_r.user_value      <= pin_word[15:0];
    end
  end

  // same value feeds programming and jtag readers
  assign user_value = pin_settings_r.user_value;

  assign cfg_wr  = wr_en_r && (wr_addr_r == OFS_CFG_CTRL);
  // lock bits move only after the unlock sequence
  assign lock_wr = cfg_wr && sys_unlocked;

  // lock bits; settings must be loaded before they matter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      remap_lock_r  <= REMAP_LOCK_RST;
      moddis_lock_r <= MODDIS_LOCK_RST;
    end else if (lock_wr) begin
      // one-shot remap lock sticks once set
      if (hwdata[REMAP_LOCK_BIT] ||
          !(pin_settings_r.remap_one_shot && remap_lock_r)) begin
        remap_lock_r <= hwdata[REMAP_LOCK_BIT];
      end
      if (hwdata[MODDIS_LOCK_BIT] ||
          !(pin_settings_r.moddis_one_shot && moddis_lock_r)) begin
        moddis_lock_r <= hwdata[MODDIS_LOCK_BIT];
      end
    end
  end

  // jtag controls: default loaded once, then software owns them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jtag_en_r   <= JTAG_EN_RST;
      tdo_use_r   <= TDO_USE_RST;
      ctrl_init_r <= 1'b0;
    end else if (loaded && !ctrl_init_r) begin
      jtag_en_r   <= jtag_default;
      ctrl_init_r <= 1'b1;
    end else if (cfg_wr) begin
      jtag_en_r <= hwdata[JTAG_EN_BIT];
      tdo_use_r <= hwdata[TDO_USE_BIT];
    end
  end

  // one packed view of the control flops, so each flop keeps a single writer
  assign cfg_ctrl_r = {remap_lock_r, moddis_lock_r, jtag_en_r, tdo_use_r};

  assign remap_writes_blocked  = cfg_ctrl_r.remap_lock;
  assign moddis_writes_blocked = cfg_ctrl_r.moddis_lock;

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      // absent usb fields read as reserved ones
      OFS_PLL_WORD: rd_data = USB_PRESENT ? pll_word : (pll_word | USB_FIELDS_MASK);
      OFS_PIN_WORD: rd_data = pin_word & PIN_WORD_IMPL_MASK;
      OFS_CFG_CTRL: begin
        rd_data[REMAP_LOCK_BIT]  = cfg_ctrl_r.remap_lock;
        rd_data[MODDIS_LOCK_BIT] = cfg_ctrl_r.moddis_lock;
        rd_data[JTAG_EN_BIT]     = cfg_ctrl_r.jtag_port_enable;
        rd_data[TDO_USE_BIT]     = cfg_ctrl_r.two_wire_tdo_use;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------------
  // checks on the block's own behaviour

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence seq_rd_pin;
    hsel && htrans == HTRANS_NONSEQ && !hwrite && hready && hreadyout
      && haddr[7:0] == OFS_PIN_WORD;
  endsequence

  sequence seq_cfg_wr_locked_remap;
    hsel && htrans == HTRANS_NONSEQ && hwrite && hready && hreadyout
      && haddr[7:0] == OFS_CFG_CTRL && pin_settings_r.remap_one_shot
      && cfg_ctrl_r.remap_lock;
  endsequence

  AST_OUT_DIV_256: assert property (
    loaded && pll_word[PLL_ODIV_LSB+:3] == 3'h7 |=> pll_settings_r.out_div == 9'h100)
    else $error("pll output divisor code 7 did not give 256");

  AST_OUT_DIV_64: assert property (
    loaded && pll_word[PLL_ODIV_LSB+:3] == 3'h6 |=> pll_settings_r.out_div == 9'h040)
    else $error("pll output divisor code 6 did not give 64");

  AST_USB_BYPASS: assert property (
    loaded && USB_PRESENT && pll_word[USB_BYPASS_BIT]
      |=> pll_settings_r.usb_pll_bypass && !pll_settings_r.usb_pll_enable)
    else $error("usb pll not bypassed when bypass bit set");

  AST_USB_IDIV: assert property (
    loaded && USB_PRESENT && pll_word[USB_IDIV_LSB+:3] == 3'h6
      |=> pll_settings_r.usb_pll_in_divider == 4'ha)
    else $error("usb pll input divider code 6 not 10");

  AST_MULT: assert property (
    loaded |=> pll_settings_r.mult == ((pll_word[PLL_MULT_LSB+:3] == 3'h7) ? 5'h18
                 : 5'h0f + {2'h0, pll_word[PLL_MULT_LSB+:3]}))
    else $error("pll multiplier decode wrong");

  AST_IDIV: assert property (
    loaded && pll_word[PLL_IDIV_LSB+:3] == 3'h7 |=> pll_settings_r.in_div == 4'hc)
    else $error("pll input divider code 7 not 12");

  AST_OUT_DIV_ONE: assert property (
    loaded && pll_word[PLL_ODIV_LSB+:3] == 3'h0 |=> pll_settings_r.out_div == 9'h001)
    else $error("pll output divisor code 0 did not give 1");

  AST_USB_ENABLE: assert property (
    loaded && USB_PRESENT && !pll_word[USB_BYPASS_BIT]
      |=> pll_settings_r.usb_pll_enable && !pll_settings_r.usb_pll_bypass)
    else $error("usb pll not enabled when bypass bit clear");

  AST_MULT_15: assert property (
    loaded && pll_word[PLL_MULT_LSB+:3] == 3'h0 |=> pll_settings_r.mult == 5'h0f)
    else $error("pll multiplier code 0 not 15");

  AST_IDIV_ONE: assert property (
    loaded && pll_word[PLL_IDIV_LSB+:3] == 3'h0 |=> pll_settings_r.in_div == 4'h1)
    else $error("pll input divider code 0 not 1");

  AST_PIN_OWNERS: assert property (
    loaded |=> pin_settings_r.vbus_pin_owner == $past(pin_word[VBUS_OWNER_BIT])
               && pin_settings_r.id_pin_owner == $past(pin_word[ID_OWNER_BIT]))
    else $error("pin ownership does not follow the pin word");

  AST_USER_VALUE: assert property (
    loaded ##1 1'b1 |-> user_value == $past(pin_word[15:0]))
    else $error("user value does not match the pin word");

  AST_PIN_ZEROS: assert property (
    seq_rd_pin |=> hrdata[27:16] == 12'h000)
    else $error("unimplemented pin word bits read nonzero");

  AST_USB_ABSENT: assert property (
    !USB_PRESENT && config_valid_r |-> !pll_settings_r.usb_pll_enable
      && pll_settings_r.usb_pll_in_divider == 4'h0)
    else $error("usb pll fields active on a part without usb");

  AST_REMAP_BLOCK: assert property (
    lock_wr && hwdata[REMAP_LOCK_BIT] |=> remap_writes_blocked)
    else $error("remap writes not blocked after lock");

  AST_JTAG_WRITE: assert property (
    ctrl_init_r && cfg_wr |=> cfg_ctrl_r.jtag_port_enable == $past(hwdata[JTAG_EN_BIT]))
    else $error("jtag enable did not take the written value");

  AST_TDO_WRITE: assert property (
    ctrl_init_r && cfg_wr |=> cfg_ctrl_r.two_wire_tdo_use == $past(hwdata[TDO_USE_BIT]))
    else $error("tdo use did not take the written value");

  AST_NO_UNLOCK: assert property (
    cfg_wr && !sys_unlocked |=> $stable(cfg_ctrl_r.remap_lock)
      && $stable(cfg_ctrl_r.moddis_lock))
    else $error("lock bit changed without unlock");

  AST_FROZEN: assert property (
    config_valid_r |=> $stable(pll_settings_r) && $stable(pin_settings_r))
    else $error("configuration changed after load");

  AST_ONE_SHOT: assert property (
    seq_cfg_wr_locked_remap ##1 sys_unlocked |=> cfg_ctrl_r.remap_lock [*2])
    else $error("one-shot remap lock was cleared");

  AST_MODDIS_STICK: assert property (
    pin_settings_r.moddis_one_shot && cfg_ctrl_r.moddis_lock |=> cfg_ctrl_r.moddis_lock)
    else $error("one-shot module-disable lock was cleared");

  AST_REMAP_STICK: assert property (
    pin_settings_r.remap_one_shot && cfg_ctrl_r.remap_lock |=> cfg_ctrl_r.remap_lock)
    else $error("one-shot remap lock was cleared");

endmodule

// *** hw/cfg_loader_pkg.sv ***
// constants, carriers and decode functions for the configuration word loader
package cfg_loader_pkg;

  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] OFS_PLL_WORD = 8'h00;
  localparam logic [7:0] OFS_PIN_WORD = 8'h04;
  localparam logic [7:0] OFS_CFG_CTRL = 8'h08;

  // pll setup word field positions
  localparam int PLL_ODIV_LSB   = 16;
  localparam int USB_BYPASS_BIT = 15;
  localparam int USB_IDIV_LSB   = 8;
  localparam int PLL_MULT_LSB   = 4;
  localparam int PLL_IDIV_LSB   = 0;
  localparam logic [31:0] USB_FIELDS_MASK = 32'h0000_8700;

  // pin ownership word field positions
  localparam int VBUS_OWNER_BIT  = 31;
  localparam int ID_OWNER_BIT    = 30;
  localparam int REMAP_1SHOT_BIT = 29;
  localparam int MODDIS_1SHOT_BIT = 28;
  localparam logic [31:0] PIN_WORD_IMPL_MASK = 32'hf000_ffff;

  // configuration control field positions and reset values
  localparam int REMAP_LOCK_BIT  = 13;
  localparam int MODDIS_LOCK_BIT = 12;
  localparam int JTAG_EN_BIT     = 3;
  localparam int TDO_USE_BIT     = 0;
  localparam logic REMAP_LOCK_RST = 1'b0;
  localparam logic MODDIS_LOCK_RST = 1'b0;
  localparam logic JTAG_EN_RST   = 1'b0;
  localparam logic TDO_USE_RST   = 1'b1;

  // sync stages plus one capture edge before the words are valid
  localparam logic [1:0] LOAD_EDGES = 2'h3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [8:0] out_div;
    logic [4:0] mult;
    logic [3:0] in_div;
    logic       usb_pll_enable;
    logic       usb_pll_bypass;
    logic [3:0] usb_pll_in_divider;
  } pll_settings_t;

  typedef struct packed {
    logic        vbus_pin_owner;
    logic        id_pin_owner;
    logic        remap_one_shot;
    logic        moddis_one_shot;
    logic [15:0] user_value;
  } pin_settings_t;

  typedef struct packed {
    logic remap_lock;
    logic moddis_lock;
    logic jtag_port_enable;
    logic two_wire_tdo_use;
  } cfg_ctrl_t;

  // shared by the system and the usb input dividers
  function automatic logic [3:0] in_div_decode(input logic [2:0] code);
    case (code)
      3'h6:    in_div_decode = 4'ha;
      3'h7:    in_div_decode = 4'hc;
      default: in_div_decode = {1'b0, code} + 4'h1;
    endcase
  endfunction

  function automatic logic [4:0] mult_decode(input logic [2:0] code);
    mult_decode = (code == 3'h7) ? 5'h18 : 5'h0f + {2'h0, code};
  endfunction

  function automatic logic [8:0] out_div_decode(input logic [2:0] code);
    out_div_decode = (code == 3'h7) ? 9'h100 : 9'h001 << code;
  endfunction

endpackage

// *** hw/cfg_word_latch.sv ***
// two-flop synchroniser and one-time capture of a nonvolatile word
`timescale 1ns/100ps
module cfg_word_latch
  import cfg_loader_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] word_in,
  output logic      [W-1:0] word_r,
  output logic              loaded_r
);

  logic [W-1:0] sync1_r;
  logic [W-1:0] sync2_r;
  logic [1:0]   edge_cnt_r;

  // synchroniser, first stage read only by second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= word_in;
      sync2_r <= sync1_r;
    end
  end

  // capture once after release, frozen until next reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_cnt_r <= 2'h0;
      word_r     <= '0;
      loaded_r   <= 1'b0;
    end else if (!loaded_r) begin
      edge_cnt_r <= edge_cnt_r + 2'h1;
      if (edge_cnt_r == LOAD_EDGES - 2'h1) begin
        word_r   <= sync2_r;
        loaded_r <= 1'b1;
      end
    end
  end

endmodule
